// ==== core/siup_pkg.sv ====
package siup_pkg;

  // Data path shape
  localparam int unsigned DATA_W         = 128;
  localparam int unsigned ADDR_W         = 48;
  localparam int unsigned IDX_W          = 10;
  localparam logic [IDX_W-1:0] LAST_WORD = 10'h1ff;  // 512 words, 8 Kbyte

  // Sequencing counts in user clock cycles
  localparam logic [31:0] PREP_CYCLES  = 32'h0000_0006;
  localparam logic [31:0] INIT_CYCLES  = 32'h0000_0010;
  localparam logic [31:0] ARP_CYCLES   = 32'h0000_0020;
  localparam logic [31:0] CLOSE_CYCLES = 32'h0000_0010;

  // Least capabilities that the target must offer
  localparam logic [31:0] MIN_CAPSULE     = 32'h0000_0204;
  localparam logic [15:0] MIN_QUEUE       = 16'h0080;
  localparam logic [15:0] MIN_OUTSTANDING = 16'h0080;

  // Fault cause bit positions
  localparam int unsigned F_NOT_FOUND   = 0;
  localparam int unsigned F_AUTH        = 1;
  localparam int unsigned F_CAPS        = 2;
  localparam int unsigned F_ADM_TIMEOUT = 9;
  localparam logic [31:0] FAULT_MASK    = 32'h003f_3f07;

  // Capacity is whole 8 Kbyte blocks
  localparam logic [47:0] CAP_ALIGN = 48'hffff_ffff_fff0;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0001;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_CONN      = 8'h04;
  localparam logic [7:0] REG_CAPSULE   = 8'h08;
  localparam logic [7:0] REG_QUEUE     = 8'h0c;
  localparam logic [7:0] REG_CAP_LO    = 8'h10;
  localparam logic [7:0] REG_CAP_HI    = 8'h14;
  localparam logic [7:0] REG_COMPL     = 8'h18;
  localparam logic [7:0] REG_FAULT     = 8'h1c;
  localparam logic [7:0] REG_STATUS    = 8'h20;
  localparam logic [7:0] REG_WSUM      = 8'h24;
  localparam logic [7:0] REG_RETRANS   = 8'h28;
  localparam logic [7:0] REG_ARP_REPLY = 8'h2c;
  localparam logic [7:0] REG_PEER      = 8'h30;

  // Control register fields
  localparam int unsigned CTRL_PRESENT = 0;
  localparam int unsigned CTRL_AUTH    = 1;

endpackage : siup_pkg

// ==== core/siup_rd_if.sv ====
`timescale 1ns/1ns
// Read command handoff between sequencer and data streamer
interface siup_rd_if;
  logic                        start;
  logic [siup_pkg::ADDR_W-1:0] addr;
  logic                        done;

  modport main   (output start, output addr, input done);
  modport stream (input start, input addr, output done);
endinterface : siup_rd_if

// ==== core/siup_rd_stream.sv ====
`timescale 1ns/1ns
module siup_rd_stream (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        read_pause_i,
  output logic      [siup_pkg::DATA_W-1:0] read_word_o,
  output logic                             read_word_valid_o,
  siup_rd_if.stream                        rd
);

  logic                       pause_d1;
  logic                       pause_d2;
  logic                       active;
  logic [siup_pkg::IDX_W-1:0] idx;
  logic [siup_pkg::ADDR_W-1:0] addr;
  logic                       go;

  // First pause stage sets the stop latency, both the resume delay
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pause_d1 <= 1'b0;
      pause_d2 <= 1'b0;
    end else begin
      pause_d1 <= read_pause_i;
      pause_d2 <= pause_d1;
    end
  end

  // Resume after two quiet cycles
  assign go = active & ~pause_d1 & ~pause_d2;  // R7 R24

  // Word counter for one 8 Kbyte command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active <= 1'b0;
      idx    <= '0;
      addr   <= '0;
    end else if (rd.start) begin
      active <= 1'b1;
      idx    <= '0;
      addr   <= rd.addr;
    end else if (go) begin
      idx <= idx + 10'h001;
      if (idx == siup_pkg::LAST_WORD) begin
        active <= 1'b0;  // R24
      end
    end
  end

  // Registered data pattern
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      read_word_valid_o <= 1'b0;
      read_word_o       <= '0;
      rd.done           <= 1'b0;
    end else begin
      read_word_valid_o <= go;  // R2 R7
      rd.done           <= go & (idx == siup_pkg::LAST_WORD);
      if (go) begin
        read_word_o <= {16'h0000, addr, 54'h0, idx};
      end
    end
  end

endmodule : siup_rd_stream

// ==== core/siup_user_port.sv ====
`timescale 1ns/1ns
// Function
// R1: Write command carries 512 words of 128 bits while write request high.
// R2: Accepted read returns 512 qualified words of read data.
// R3: Wait request low only when command or write data can be taken.
// R4: User holds write word steady while wait request is high.
// R5: User gives block address in 512-byte units, low four bits zero.
// R6: User never raises read with write, nor read during write.
// R7: Read pause stops read valid two cycles later.
// R8: Enable rising connects, falling disconnects; only changed while idle.
// R9: Busy rises on enable change or command, falls on completion.
// R10: Fault flag high whenever fault cause nonzero, cleared only by reset.
// R11: Cause bits 0..2: not found, authentication, weak capabilities.
// R12: Cause bits 8..13 report admin port faults.
// R13: Cause bits 16..21 report IO faults; other bits reserved zero.
// R14: Capacity zero until connected, then valid with low four bits zero.
// R15: Capability word: capsule 31:0, queue 47:32, outstanding 63:48.
// R16: Completion status words carry status in 15:1, bit 0 zero.
// R17: Retransmit timeout in clock periods paces retransmissions.
// R18: Response timeout in clock periods raises fault; zero disables.
// R19: Address mode 0 resolves peer address, 1 uses fixed input.
// R20: User keeps parameter inputs valid during connection setup.
// R21: Local name is 207 build bytes plus 16 input bytes.
// R22: Target name byte 0 first, unused bytes zero.
// R23: After command accept, wait request high at least six cycles.
// R24: Read resumes after two low pause cycles; 512 valid cycles each.
module siup_user_port #(
  parameter logic [31:0] CORE_VERSION = 32'h0001_0000  // Arbitrary value
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  input  wire logic          link_session_enable_i,
  output logic               session_active_o,
  output logic               engine_busy_o,
  output logic               fault_flag_o,
  output logic      [31:0]   fault_cause_o,
  output logic      [47:0]   target_capacity_o,
  output logic      [63:0]   target_capability_info_o,
  output logic      [15:0]   admin_completion_status_o,
  output logic      [15:0]   io_completion_status_o,
  output logic      [31:0]   core_version_o,
  output logic      [127:0]  test_points_o,
  input  wire logic [31:0]   retransmit_timeout_i,
  input  wire logic [31:0]   response_timeout_i,
  input  wire logic          target_hw_addr_mode_i,
  input  wire logic [47:0]   target_hw_addr_i,
  input  wire logic [31:0]   target_net_addr_i,
  input  wire logic [31:0]   local_net_addr_i,
  input  wire logic [15:0]   local_admin_port_i,
  input  wire logic [15:0]   local_io_port_i,
  input  wire logic [1783:0] target_name_i,
  input  wire logic [47:0]   cmd_block_address_i,
  input  wire logic          read_request_i,
  input  wire logic          write_request_i,
  output logic               wait_request_o,
  input  wire logic [127:0]  write_word_i,
  output logic      [127:0]  read_word_o,
  output logic               read_word_valid_o,
  input  wire logic          read_pause_i
);

  typedef enum logic [3:0] {
    ST_INIT, ST_OFF, ST_CONNECT, ST_READY, ST_WR_PREP, ST_WR_DATA,
    ST_RD_PREP, ST_RD_DATA, ST_CLOSE, ST_FAULT
  } siup_state_t;

  siup_state_t state;
  siup_rd_if   rd_if ();

  logic [31:0] ctrl;
  logic [31:0] conn_cycles;
  logic [31:0] capsule;
  logic [31:0] queue_info;
  logic [47:0] capacity_src;
  logic [31:0] compl;
  logic [31:0] arp_reply;
  logic [31:0] fault_cause;
  logic [31:0] hw_fault;
  logic [31:0] write_sum;
  logic [31:0] retrans_count;
  logic [31:0] timer;
  logic [31:0] rt_timer;
  logic [9:0]  word_cnt;
  logic        arp_done;
  logic        en_prev;
  logic        en_rise;
  logic        en_fall;
  logic        wb_hit;
  logic        wb_wr;
  logic        wr_take;
  logic        rd_take;
  logic        word_take;
  logic        handshake;
  logic        caps_bad;
  logic [47:0] peer_hw_addr;
  logic [31:0] peer_net_addr;
  logic [31:0] local_net_snap;
  logic [15:0] port_snap;

  // Byte-lane merge for every writable register except the fault cause register
  function automatic logic [31:0] siup_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : siup_merge

  // Bus strobes; write lands on the acknowledging edge
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  // One wait state, ack dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  // Register read mux; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (wb_hit) begin
      case (wb_adr_i)
        siup_pkg::REG_CTRL:      wb_dat_o <= ctrl;
        siup_pkg::REG_CONN:      wb_dat_o <= conn_cycles;
        siup_pkg::REG_CAPSULE:   wb_dat_o <= capsule;
        siup_pkg::REG_QUEUE:     wb_dat_o <= queue_info;
        siup_pkg::REG_CAP_LO:    wb_dat_o <= capacity_src[31:0];
        siup_pkg::REG_CAP_HI:    wb_dat_o <= {16'h0000, capacity_src[47:32]};
        siup_pkg::REG_COMPL:     wb_dat_o <= compl;
        siup_pkg::REG_FAULT:     wb_dat_o <= fault_cause;
        siup_pkg::REG_STATUS:    wb_dat_o <= {24'h000000, 4'(state),
                                   fault_flag_o, engine_busy_o,
                                   session_active_o, wait_request_o};
        siup_pkg::REG_WSUM:      wb_dat_o <= write_sum;
        siup_pkg::REG_RETRANS:   wb_dat_o <= retrans_count;
        siup_pkg::REG_ARP_REPLY: wb_dat_o <= arp_reply;
        siup_pkg::REG_PEER:      wb_dat_o <= peer_hw_addr[31:0];
        default:                 wb_dat_o <= '0;
      endcase
    end
  end

  // Target model registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl         <= siup_pkg::CTRL_RST;
      conn_cycles  <= '0;
      capsule      <= '0;
      queue_info   <= '0;
      capacity_src <= '0;
      compl        <= '0;
      arp_reply    <= '0;
    end else if (wb_wr) begin
      case (wb_adr_i)
        siup_pkg::REG_CTRL:
          ctrl <= siup_merge(ctrl, wb_dat_i, wb_sel_i);
        siup_pkg::REG_CONN:
          conn_cycles <= siup_merge(conn_cycles, wb_dat_i, wb_sel_i);
        siup_pkg::REG_CAPSULE:
          capsule <= siup_merge(capsule, wb_dat_i, wb_sel_i);
        siup_pkg::REG_QUEUE:
          queue_info <= siup_merge(queue_info, wb_dat_i, wb_sel_i);
        siup_pkg::REG_CAP_LO:
          capacity_src[31:0] <= siup_merge(capacity_src[31:0], wb_dat_i,
                                           wb_sel_i);
        siup_pkg::REG_CAP_HI:
          capacity_src[47:32] <= 16'(siup_merge({16'h0000,
                                   capacity_src[47:32]}, wb_dat_i, wb_sel_i));
        siup_pkg::REG_COMPL:
          compl <= siup_merge(compl, wb_dat_i, wb_sel_i);
        siup_pkg::REG_ARP_REPLY:
          arp_reply <= siup_merge(arp_reply, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // Sticky causes, reset clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_cause <= '0;  // R10
    end else if (wb_wr && wb_adr_i == siup_pkg::REG_FAULT) begin
      fault_cause <= fault_cause | hw_fault
                   | (wb_dat_i & siup_pkg::FAULT_MASK);  // R12 R13
    end else begin
      fault_cause <= fault_cause | hw_fault;
    end
  end

  assign fault_cause_o = fault_cause;
  assign fault_flag_o  = |fault_cause;  // R10

  // Enable edges, sampled as synchronous input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_prev <= 1'b0;
    end else begin
      en_prev <= link_session_enable_i;
    end
  end

  assign en_rise = link_session_enable_i & ~en_prev;  // R8
  assign en_fall = ~link_session_enable_i & en_prev;  // R8

  // Handshakes with the user command port
  assign wait_request_o = ~(((state == ST_READY) & link_session_enable_i)
                          | (state == ST_WR_DATA));  // R3
  assign wr_take   = write_request_i & ~wait_request_o
                   & (state == ST_READY);
  assign rd_take   = read_request_i & ~write_request_i & ~wait_request_o
                   & (state == ST_READY);
  assign word_take = write_request_i & ~wait_request_o;  // R1 R4
  assign engine_busy_o = (state != ST_OFF) & (state != ST_READY);  // R9

  // Connection checks and detected faults
  assign handshake = (state == ST_CONNECT)
                   & (target_hw_addr_mode_i | arp_done);  // R19
  assign caps_bad  = (capsule < siup_pkg::MIN_CAPSULE)
                   | (queue_info[15:0] < siup_pkg::MIN_QUEUE)
                   | (queue_info[31:16] < siup_pkg::MIN_OUTSTANDING);

  always_comb begin
    hw_fault = '0;
    if (handshake && timer == conn_cycles) begin
      hw_fault[siup_pkg::F_NOT_FOUND] = ~ctrl[siup_pkg::CTRL_PRESENT]
                                      | ~(|target_name_i);  // R11
      hw_fault[siup_pkg::F_AUTH] = ctrl[siup_pkg::CTRL_AUTH];  // R11
      hw_fault[siup_pkg::F_CAPS] = caps_bad;  // R11
    end
    if (state == ST_CONNECT && response_timeout_i != 32'h0
        && timer >= response_timeout_i) begin
      hw_fault[siup_pkg::F_ADM_TIMEOUT] = 1'b1;  // R18
    end
  end

  // Main sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= ST_INIT;
      timer    <= '0;
      word_cnt <= '0;
      arp_done <= 1'b0;
    end else if (fault_flag_o) begin
      state <= ST_FAULT;  // Busy stays high until reset
    end else begin
      timer <= timer + 32'h1;
      case (state)
        ST_INIT: begin
          if (timer == siup_pkg::INIT_CYCLES) begin
            state <= ST_OFF;
          end
        end
        ST_OFF: begin
          timer    <= '0;
          arp_done <= 1'b0;
          if (en_rise) begin
            state <= ST_CONNECT;  // R8 R9
          end
        end
        ST_CONNECT: begin
          if (!target_hw_addr_mode_i && !arp_done
              && timer == siup_pkg::ARP_CYCLES) begin
            arp_done <= 1'b1;  // R19
            timer    <= '0;
          end else if (handshake && timer == conn_cycles
                       && hw_fault == 32'h0) begin
            state <= ST_READY;
          end
        end
        ST_READY: begin
          timer    <= '0;
          word_cnt <= 10'h001;
          if (en_fall) begin
            state <= ST_CLOSE;  // R8
          end else if (wr_take) begin
            state <= ST_WR_PREP;  // R9
          end else if (rd_take) begin
            state <= ST_RD_PREP;  // R2 R9
          end
        end
        ST_WR_PREP: begin
          if (timer == siup_pkg::PREP_CYCLES - 32'h1) begin
            state <= ST_WR_DATA;  // R23
          end
        end
        ST_WR_DATA: begin
          if (word_take) begin
            word_cnt <= word_cnt + 10'h001;
            if (word_cnt == siup_pkg::LAST_WORD) begin
              state <= ST_READY;  // R1
            end
          end
        end
        ST_RD_PREP: begin
          if (timer == siup_pkg::PREP_CYCLES - 32'h1) begin
            state <= ST_RD_DATA;  // R23
          end
        end
        ST_RD_DATA: begin
          if (rd_if.done) begin
            state <= ST_READY;
          end
        end
        ST_CLOSE: begin
          if (timer == siup_pkg::CLOSE_CYCLES) begin
            state <= ST_OFF;
          end
        end
        default: state <= ST_FAULT;
      endcase
    end
  end

  // Retransmit pacing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rt_timer      <= '0;
      retrans_count <= '0;
    end else if (handshake && retransmit_timeout_i != 32'h0) begin
      if (rt_timer >= retransmit_timeout_i - 32'h1) begin
        rt_timer      <= '0;
        retrans_count <= retrans_count + 32'h1;  // R17
      end else begin
        rt_timer <= rt_timer + 32'h1;
      end
    end else begin
      rt_timer <= '0;
    end
  end

  // Snapshot at connect
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      peer_hw_addr   <= '0;
      peer_net_addr  <= '0;
      local_net_snap <= '0;
      port_snap      <= '0;
    end else if (state == ST_OFF && en_rise) begin
      peer_net_addr  <= target_net_addr_i;
      local_net_snap <= local_net_addr_i;
      port_snap      <= local_admin_port_i ^ local_io_port_i;
      if (target_hw_addr_mode_i) begin
        peer_hw_addr <= target_hw_addr_i;  // R19
      end
    end else if (state == ST_CONNECT && !target_hw_addr_mode_i
                 && timer == siup_pkg::ARP_CYCLES && !arp_done) begin
      peer_hw_addr <= {16'h0000, arp_reply};  // R19
    end
  end

  // Session and capacity on success
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      session_active_o  <= 1'b0;
      target_capacity_o <= '0;  // R14
    end else if (state == ST_CONNECT && handshake
                 && timer == conn_cycles && hw_fault == 32'h0
                 && !fault_flag_o) begin
      session_active_o  <= 1'b1;
      target_capacity_o <= capacity_src & siup_pkg::CAP_ALIGN;  // R14
    end else if (state == ST_CLOSE && timer == siup_pkg::CLOSE_CYCLES) begin
      session_active_o <= 1'b0;
    end
  end

  // Checksum of write words
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      write_sum <= '0;
    end else if (wr_take || (state == ST_WR_DATA && word_take)) begin
      write_sum <= write_sum ^ write_word_i[31:0] ^ write_word_i[63:32]
                 ^ write_word_i[95:64] ^ write_word_i[127:96];
    end
  end

  // Read start to streamer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_if.start <= 1'b0;
      rd_if.addr  <= '0;
    end else begin
      rd_if.start <= (state == ST_RD_PREP)
                   & (timer == siup_pkg::PREP_CYCLES - 32'h1);
      if (rd_take) begin
        rd_if.addr <= cmd_block_address_i;
      end
    end
  end

  siup_rd_stream u_rd_stream (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .read_pause_i      (read_pause_i),
    .read_word_o       (read_word_o),
    .read_word_valid_o (read_word_valid_o),
    .rd                (rd_if.stream)
  );

  // Status words; completion status bit 0 zero
  assign target_capability_info_o = {queue_info[31:16], queue_info[15:0],
                                     capsule};  // R15
  assign admin_completion_status_o = {compl[15:1], 1'b0};  // R16
  assign io_completion_status_o    = {compl[31:17], 1'b0};  // R16
  assign core_version_o            = CORE_VERSION;
  assign test_points_o = {peer_hw_addr, peer_net_addr, local_net_snap,
                          port_snap};

endmodule : siup_user_port

// ==== testbench/siup_user_port_asserts.sv ====
`timescale 1ns/1ns
// Port timing checks
module siup_user_port_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        link_session_enable_i,
  input wire logic        engine_busy_o,
  input wire logic        fault_flag_o,
  input wire logic [31:0] fault_cause_o,
  input wire logic [47:0] target_capacity_o,
  input wire logic [15:0] admin_completion_status_o,
  input wire logic [15:0] io_completion_status_o,
  input wire logic        read_request_i,
  input wire logic        write_request_i,
  input wire logic        wait_request_o,
  input wire logic        read_word_valid_o,
  input wire logic        read_pause_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Flag and sticky causes
  property p_flag;
    fault_flag_o == (|fault_cause_o);
  endproperty
  a_flag: assert property (p_flag) else $error("flag mismatch");
  property p_sticky;
    (fault_cause_o & $past(fault_cause_o)) == $past(fault_cause_o);
  endproperty
  a_sticky: assert property (p_sticky) else $error("cause lost");
  property p_reserved;
    (fault_cause_o & ~siup_pkg::FAULT_MASK) == 32'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved");
  // Pause latency and resume
  property p_pause;
    read_pause_i |-> ##2 !read_word_valid_o;
  endproperty
  a_pause: assert property (p_pause) else $error("pause late");
  property p_resume;
    $rose(read_word_valid_o) |-> !$past(read_pause_i, 2)
      && !$past(read_pause_i, 3);
  endproperty
  a_resume: assert property (p_resume) else $error("early");
  // Command hold-off, busy, capacity and status checks
  property p_prep;
    (!wait_request_o && !engine_busy_o && (write_request_i || read_request_i))
      |=> (wait_request_o && engine_busy_o) [*6];
  endproperty
  a_prep: assert property (p_prep) else $error("prep short");
  property p_valid_busy;
    read_word_valid_o |-> engine_busy_o && wait_request_o;
  endproperty
  a_valid_busy: assert property (p_valid_busy) else $error("idle data");
  property p_enable;
    $changed(link_session_enable_i) && !engine_busy_o |=> engine_busy_o;
  endproperty
  a_enable: assert property (p_enable) else $error("busy missing");
  property p_cap_align;
    target_capacity_o[3:0] == 4'h0;
  endproperty
  a_cap_align: assert property (p_cap_align) else $error("capacity");
  property p_compl;
    !admin_completion_status_o[0] && !io_completion_status_o[0];
  endproperty
  a_compl: assert property (p_compl) else $error("status bit 0");
endmodule : siup_user_port_asserts

bind siup_user_port siup_user_port_asserts u_asserts (.*);

// ==== testbench/siup_user_model.sv ====
`timescale 1ns/1ns
// User logic stand-in
module siup_user_model (
  input  wire logic         clk_i,
  input  wire logic         wait_request_i,
  input  wire logic         read_word_valid_i,
  input  wire logic [127:0] read_word_i,
  output logic      [47:0]  cmd_block_address_o,
  output logic              read_request_o,
  output logic              write_request_o,
  output logic      [127:0] write_word_o,
  output logic              read_pause_o
);
  int rd_got = 0;
  int rd_bad = 0;

  // Idle user side
  initial begin
    cmd_block_address_o = 48'h0;
    read_request_o = 1'b0;
    write_request_o = 1'b0;
    write_word_o = 128'h0;
    read_pause_o = 1'b0;
  end

  // 8 Kbyte write; words held while stalled
  task automatic do_write(input logic [47:0] a);
    @(posedge clk_i);
    cmd_block_address_o <= a;
    write_request_o <= 1'b1;
    write_word_o <= 128'h1;
    for (int k = 0; k < 512; k++) begin
      do @(posedge clk_i); while (wait_request_i);
      write_word_o <= 128'(k + 2);
    end
    write_request_o <= 1'b0;
  endtask : do_write

  // Read with pause bursts
  task automatic do_read(input logic [47:0] a);
    @(posedge clk_i);
    cmd_block_address_o <= a;
    read_request_o <= 1'b1;
    do @(posedge clk_i); while (wait_request_i);
    read_request_o <= 1'b0;
    rd_got = 0;
    rd_bad = 0;
    for (int n = 0; n < 3000 && rd_got < 512; n++) begin
      @(posedge clk_i);
      if (read_word_valid_i === 1'b1) begin
        if (read_word_i !== {16'h0, a, 54'h0, 10'(rd_got)})
          rd_bad++;
        rd_got++;
      end
      read_pause_o <= (n % 9) < 3;
    end
    read_pause_o <= 1'b0;
  endtask : do_read
endmodule : siup_user_model

// ==== testbench/test_storage_initiator_user_port.sv ====
`timescale 1ns/1ns
module test_storage_initiator_user_port;
  logic          clk_i = 1'b0;
  logic          rst_i = 1'b1;
  logic          wb_cyc_i = 1'b0;
  logic          wb_stb_i = 1'b0;
  logic          wb_we_i = 1'b0;
  logic [7:0]    wb_adr_i = 8'h0;
  logic [3:0]    wb_sel_i = 4'hf;
  logic [31:0]   wb_dat_i = 32'h0;
  logic [31:0]   wb_dat_o, fault_cause_o, core_version_o, q;
  logic          wb_ack_o, session_active_o, engine_busy_o, fault_flag_o;
  logic          link_session_enable_i = 1'b0;
  logic [47:0]   target_capacity_o, cmd_block_address_i;
  logic [63:0]   target_capability_info_o;
  logic [15:0]   admin_completion_status_o, io_completion_status_o;
  logic [127:0]  test_points_o, write_word_i, read_word_o;
  logic [31:0]   retransmit_timeout_i = 32'h10;
  logic [31:0]   response_timeout_i = 32'h0;
  logic          target_hw_addr_mode_i = 1'b1;
  logic [47:0]   target_hw_addr_i = 48'h0a0b_0c0d_0e0f;
  logic [31:0]   target_net_addr_i = 32'hc0a8_0002;
  logic [31:0]   local_net_addr_i = 32'hc0a8_0001;
  logic [15:0]   local_admin_port_i = 16'h1000;
  logic [15:0]   local_io_port_i = 16'h1001;
  logic [1783:0] target_name_i = 1784'h74;
  logic          read_request_i, write_request_i, wait_request_o;
  logic          read_word_valid_o, read_pause_i;
  int            failures = 0;
  int            checks_done = 0;

  siup_user_port dut (.*);
  siup_user_model um (
    .clk_i               (clk_i),
    .wait_request_i      (wait_request_o),
    .read_word_valid_i   (read_word_valid_o),
    .read_word_i         (read_word_o),
    .cmd_block_address_o (cmd_block_address_i),
    .read_request_o      (read_request_i),
    .write_request_o     (write_request_i),
    .write_word_o        (write_word_i),
    .read_pause_o        (read_pause_i)
  );

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  task automatic report_and_stop;
    if (failures == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Wishbone cycle held until ack
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic wait_idle;
    repeat (2) @(posedge clk_i);
    for (int n = 0; n < 3000 && engine_busy_o !== 1'b0; n++)
      @(posedge clk_i);
  endtask : wait_idle

  task automatic do_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_idle();
  endtask : do_reset

  // Load target answers, then connect
  task automatic setup(input logic [31:0] capsule);
    wb(1'b1, siup_pkg::REG_CAPSULE, capsule, q);
    wb(1'b1, siup_pkg::REG_QUEUE, 32'h0080_0080, q);
    wb(1'b1, siup_pkg::REG_CAP_LO, 32'h1234_567f, q);
    wb(1'b1, siup_pkg::REG_CAP_HI, 32'h0000_0001, q);
    wb(1'b1, siup_pkg::REG_COMPL, 32'h0003_0005, q);
    @(posedge clk_i);
    link_session_enable_i <= 1'b1;
  endtask : setup

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    report_and_stop();
  end

  initial begin
    do_reset();
    wb(1'b0, siup_pkg::REG_CTRL, 32'h0, q);
    chk(q, siup_pkg::CTRL_RST);
    wb(1'b0, 8'h3c, 32'h0, q);
    chk(q, 32'h0);
    chk(target_capacity_o, 48'h0);
    setup(32'h204);
    wait_idle();
    chk(session_active_o, 1'b1);
    chk(target_capacity_o, 48'h0001_1234_5670);
    chk(target_capability_info_o, {32'h0080_0080, 32'h204});
    chk({admin_completion_status_o, io_completion_status_o}, 32'h4_0002);
    chk(test_points_o, {target_hw_addr_i, 64'hc0a8_0002_c0a8_0001, 16'h1});
    um.do_write(48'h10);
    wait_idle();
    wb(1'b0, siup_pkg::REG_WSUM, 32'h0, q);
    chk(q, 32'h200);
    um.do_read(48'h20);
    wait_idle();
    chk(um.rd_got, 512);
    chk(um.rd_bad, 0);
    @(posedge clk_i);
    link_session_enable_i <= 1'b0;
    wait_idle();
    chk(session_active_o, 1'b0);
    wb(1'b1, siup_pkg::REG_FAULT, 32'h0000_ff08, q);
    @(posedge clk_i);
    chk(fault_cause_o, 32'h0000_3f00);
    chk(fault_flag_o, 1'b1);
    do_reset();
    chk(fault_flag_o, 1'b0);
    setup(32'h203);
    for (int n = 0; n < 500 && fault_flag_o !== 1'b1; n++)
      @(posedge clk_i);
    chk(fault_cause_o, 32'h4);
    chk(session_active_o, 1'b0);
    report_and_stop();
  end
endmodule : test_storage_initiator_user_port
